// >>> core/scs_pkg.sv
`default_nettype none
package scs_pkg;
   // Converter geometry
   localparam int unsigned NBITS          = 14;
   localparam logic [13:0] CODE_MIN       = 14'h0000;
   localparam logic [13:0] CODE_MID       = 14'h2000;
   localparam logic [13:0] CODE_MAX       = 14'h3fff;
   localparam logic [13:0] CODE_RESET     = 14'h0000;
   // Timing at 100 MHz system clock
   localparam int unsigned CLK_PERIOD_PS  = 10000;
   localparam int unsigned APERTURE_NS    = 20;
   localparam int unsigned APERTURE_CYC   = (APERTURE_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
   localparam int unsigned SETTLE_NS      = 20;
   localparam int unsigned SETTLE_CYC     = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
   localparam int unsigned BIT_NS         = 60;
   localparam int unsigned BIT_CYC        = (BIT_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
   localparam int unsigned MAX_RATE_KSPS  = 500;

   // Analog switch controls of the capacitor arrays
   typedef struct packed {
      logic samp_pos;   // Comparator-side pos terminal to ground
      logic samp_neg;   // Comparator-side neg terminal to ground
      logic arr_inputs; // Array bottom plates to inputs
      logic arr_ground; // Array bottom plates to ground
   } scs_sw_s;

   // Conversion result carrier
   typedef struct packed {
      logic [13:0] code;
      logic        over;
      logic        under;
   } scs_result_s;

   typedef enum logic [5:0] {
      ST_ACQ    = 6'b000001,
      ST_APER   = 6'b000010,
      ST_OPEN   = 6'b000100,
      ST_GND    = 6'b001000,
      ST_BIT    = 6'b010000,
      ST_DONE   = 6'b100000
   } scs_state_e;
endpackage
`default_nettype wire

// >>> core/scs_bit_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Internal conversion clock: a countdown reloaded on every load, held at zero, pulse at zero
module scs_bit_timer #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             i_clk_sys,
   input  wire logic             i_resetn,
   input  wire logic             i_load,
   input  wire logic [WIDTH-1:0] i_count,
   output logic                  o_tick
);
   logic [WIDTH-1:0] cnt_q;

   // A zero-width counter cannot count
   if (WIDTH == 0) begin : g_width_check
      $error("scs_bit_timer needs a width of at least one bit");
   end

   // Down counter, holds at zero, tick registered as it steps from one to zero
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_q  <= '0;
         o_tick <= 1'b0;
      end else if (i_load) begin
         cnt_q  <= i_count;
         o_tick <= 1'b0;
      end else begin
         o_tick <= (cnt_q == WIDTH'(1));
         if (cnt_q != '0) begin
            cnt_q <= cnt_q - WIDTH'(1);
         end
      end
   end
endmodule
`default_nettype wire

// >>> core/scs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer #(
   parameter int unsigned BITS = scs_pkg::NBITS
) (
   input  wire logic              i_clk_sys,
   input  wire logic              i_resetn,
   input  wire logic              i_convert_start,
   input  wire logic              i_comp_high,
   input  wire logic              i_over_range,
   input  wire logic              i_under_range,
   output scs_pkg::scs_sw_s       o_sw,
   output logic [13:0]            o_dac_bits,
   output logic                   o_hold,
   output logic                   o_power_up,
   output logic                   o_busy,
   output logic                   o_done,
   output scs_pkg::scs_result_s   o_result
);
   import scs_pkg::*;

   // Elaboration checks: the array is fixed at 14 bits, every count must tick
   if (BITS != NBITS) begin : g_bits_check
      $error("scs_sequencer supports only 14 bits");
   end
   if ((APERTURE_CYC == 0) || (SETTLE_CYC == 0) || (BIT_CYC == 0)) begin : g_zero_check
      $error("scs_sequencer timing count of zero never ticks");
   end
   if ((APERTURE_CYC > 255) || (SETTLE_CYC > 255) || (BIT_CYC > 255)) begin : g_wide_check
      $error("scs_sequencer timing count overflows the 8-bit timer");
   end

   // Convert-start sync: three flops, change counts when last two agree
   // Flops reset to the pin's idle low level, so release gives no false edge
   logic [2:0] cs_sync_q;
   logic       cs_level_q;
   logic       cs_rise;
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         cs_sync_q  <= 3'h0;
         cs_level_q <= 1'b0;
      end else begin
         cs_sync_q <= {cs_sync_q[1:0], i_convert_start};
         if (cs_sync_q[1] == cs_sync_q[2]) begin
            cs_level_q <= cs_sync_q[2];
         end
      end
   end
   assign cs_rise = (cs_sync_q[1] == cs_sync_q[2]) && cs_sync_q[2] && !cs_level_q;

   scs_state_e  state_q;
   scs_state_e  state_d;
   logic [3:0]  bit_idx_q;
   logic [13:0] trial_q;
   logic        tick;
   logic        load;
   logic [7:0]  load_val;

   // Internal conversion clock, independent of any serial clock.
   // A reload of N raises the tick N cycles later and the state moves one
   // cycle after that, so each timed phase lasts N plus one cycles:
   // aperture 3, open 3, ground 3, each of the 14 bits 7, done 1.
   // From the pin's rising edge to the done pulse is 112 cycles.
   scs_bit_timer #(.WIDTH(8)) u_scs_bit_timer (
      .i_clk_sys (i_clk_sys),
      .i_resetn  (i_resetn),
      .i_load    (load),
      .i_count   (load_val),
      .o_tick    (tick)
   );

   // Next state and timer reload
   always_comb begin
      state_d  = state_q;
      load     = 1'b0;
      load_val = 8'h00;
      case (state_q)
         ST_ACQ: begin
            if (cs_rise) begin
               state_d  = ST_APER;
               load     = 1'b1;
               load_val = 8'(APERTURE_CYC);
            end
         end
         ST_APER: begin
            if (tick) begin
               state_d  = ST_OPEN;
               load     = 1'b1;
               load_val = 8'(SETTLE_CYC);
            end
         end
         ST_OPEN: begin
            if (tick) begin
               state_d  = ST_GND;
               load     = 1'b1;
               load_val = 8'(SETTLE_CYC);
            end
         end
         ST_GND: begin
            if (tick) begin
               state_d  = ST_BIT;
               load     = 1'b1;
               load_val = 8'(BIT_CYC);
            end
         end
         ST_BIT: begin
            if (tick) begin
               load     = 1'b1;
               load_val = 8'(BIT_CYC);
               if (bit_idx_q == 4'h0) begin
                  state_d = ST_DONE;
               end
            end
         end
         // One cycle to publish the code, then back to acquisition
         ST_DONE: state_d = ST_ACQ;
         default: state_d = ST_ACQ;
      endcase
   end

   // State register
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q <= ST_ACQ;
      end else begin
         state_q <= state_d;
      end
   end

   // Successive approximation register, MSB first
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         bit_idx_q <= 4'h0;
         trial_q   <= 14'h0000;
      end else if (state_q == ST_GND && tick) begin
         bit_idx_q <= 4'(NBITS - 1);
         trial_q   <= CODE_MID;
      end else if (state_q == ST_BIT && tick) begin
         // Keep or drop the tried bit, then try the next lower one
         // Comparator high: trial above the held sample, so the bit is dropped
         if (i_comp_high) begin
            trial_q[bit_idx_q] <= 1'b0;
         end
         if (bit_idx_q != 4'h0) begin
            trial_q[bit_idx_q - 4'h1] <= 1'b1;
            bit_idx_q <= bit_idx_q - 4'h1;
         end
      end
   end

   // Saturate a finished code on range flags
   function automatic logic [13:0] sat_code(input logic [13:0] raw,
                                            input logic over, input logic under);
      if (over) return CODE_MAX;
      if (under) return CODE_MIN;
      return raw;
   endfunction

   // Tracking phases: sampling switches closed, arrays still on the inputs
   function automatic logic is_tracking(input scs_state_e s);
      return (s == ST_ACQ) || (s == ST_APER);
   endfunction

   // Switch drive, array bits, hold and power follow the state
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_sw       <= '{samp_pos: 1'b1, samp_neg: 1'b1, arr_inputs: 1'b1, arr_ground: 1'b0};
         o_dac_bits <= 14'h0000;
         o_hold     <= 1'b0;
         o_power_up <= 1'b0;
      end else begin
         o_sw.samp_pos   <= is_tracking(state_d);
         o_sw.samp_neg   <= is_tracking(state_d);
         o_sw.arr_inputs <= is_tracking(state_d) || (state_d == ST_OPEN);
         o_sw.arr_ground <= (state_d == ST_GND) || (state_d == ST_BIT);
         o_dac_bits      <= (state_q == ST_BIT) ? trial_q : 14'h0000;
         o_hold          <= !is_tracking(state_d);
         o_power_up      <= (state_d != ST_ACQ);
      end
   end

   // Publish the result on completion only; held until the next one
   // Range flags are sampled in the done cycle and override the code
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_result <= '{code: CODE_RESET, over: 1'b0, under: 1'b0};
         o_done   <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (state_q == ST_DONE) begin
            o_result.code  <= sat_code(trial_q, i_over_range, i_under_range);
            o_result.over  <= i_over_range;
            o_result.under <= i_under_range;
            o_done         <= 1'b1;
         end
      end
   end

   // Busy from start edge to completion
   // Same decode as the power control, so power never lags busy
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_busy <= 1'b0;
      end else begin
         o_busy <= (state_d != ST_ACQ);
      end
   end
endmodule
`default_nettype wire

// >>> tb/scs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the conversion walk
module scs_monitor (
   input wire logic                i_clk_sys,
   input wire logic                i_resetn,
   input wire logic                i_convert_start,
   input wire logic                i_comp_high,
   input wire logic                i_over_range,
   input wire logic                i_under_range,
   input wire scs_pkg::scs_sw_s    o_sw,
   input wire logic [13:0]         o_dac_bits,
   input wire logic                o_hold,
   input wire logic                o_power_up,
   input wire logic                o_busy,
   input wire logic                o_done,
   input wire scs_pkg::scs_result_s o_result
);
   import scs_pkg::*;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   // Hold closes three cycles after busy (aperture phase); the done pulse
   // follows two settle phases, fourteen bit phases and the done cycle later
   sequence s_hold_rise;
      ##3 $rose(o_hold);
   endsequence
   sequence s_finish;
      ##105 o_done;
   endsequence
   acq_switches_a: assert property (!o_busy |-> o_sw == 4'b1110 && o_dac_bits == 14'h0000)
      else $error("switches left acquisition while idle");
   start_busy_a: assert property ($rose(i_convert_start) && !o_busy && !o_done |-> ##[2:4] o_busy)
      else $error("start edge ignored");
   open_first_a: assert property ($rose(o_sw.arr_ground) |-> !o_sw.samp_pos && !o_sw.samp_neg && $past(o_hold))
      else $error("arrays grounded before terminals opened");
   msb_first_a: assert property (o_dac_bits != 0 && $past(o_dac_bits) == 0 |-> o_dac_bits == 14'h2000)
      else $error("first trial is not half scale");
   done_pulse_a: assert property (o_done |-> !o_busy && $past(o_busy) ##1 !o_done)
      else $error("done not a single pulse ending busy");
   self_timed_a: assert property ($rose(o_busy) |-> s_hold_rise ##0 s_finish)
      else $error("hold or finish out of time");
   power_down_a: assert property (!o_done |-> o_power_up == o_busy)
      else $error("power state differs from busy");
   saturate_a: assert property (o_done && $past(i_over_range) |-> o_result.code == CODE_MAX)
      else $error("over range not saturated");
   under_sat_a: assert property (o_done && !$past(i_over_range) &&
      $past(i_under_range) |-> o_result.code == CODE_MIN)
      else $error("under range not saturated");
   result_hold_a: assert property ($changed(o_result) |-> o_done)
      else $error("result changed without done");
endmodule
bind scs_sequencer scs_monitor u_scs_monitor (.i_clk_sys, .i_resetn, .i_convert_start,
   .i_comp_high, .i_over_range, .i_under_range, .o_sw, .o_dac_bits, .o_hold, .o_power_up,
   .o_busy, .o_done, .o_result);
`default_nettype wire

// >>> tb/scs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host pin driver and comparator on the far side of the sequencer
module scs_host_model (
   input  wire logic        i_clk_sys,
   input  wire logic [13:0] i_dac_bits,
   input  wire logic        i_done,
   output var  logic        o_convert_start,
   output var  logic        o_comp_high
);
   logic [13:0] sample = 14'h0000;
   initial o_convert_start = 1'b0;
   // Comparator: high while the trial word lies above the held sample
   always_comb o_comp_high = i_dac_bits > sample;
   // One conversion: rising edge, wait for done, then a low gap
   task automatic convert(input logic [13:0] s, output int n);
      n = 0;
      sample = s;
      @(negedge i_clk_sys);
      o_convert_start = 1'b1;
      while (i_done !== 1'b1 && n < 300) begin
         @(negedge i_clk_sys);
         n++;
      end
      o_convert_start = 1'b0;
      repeat (2) @(negedge i_clk_sys);
   endtask
endmodule
`default_nettype wire

// >>> tb/scs_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
   $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module scs_sequencer_tb_top;
   import scs_pkg::*;
   logic        i_clk_sys = 1'b0;
   logic        i_resetn = 1'b0;
   logic        i_over_range = 1'b0;
   logic        i_under_range = 1'b0;
   logic        convert_start, comp_high, hold, power_up, busy, done;
   logic [13:0] dac_bits;
   scs_sw_s     sw;
   scs_result_s result;
   int          n_errors = 0;
   int          num_checks = 0;
   int          n;
   always #5 i_clk_sys = ~i_clk_sys;
   scs_sequencer u_scs_sequencer (.i_clk_sys, .i_resetn, .i_convert_start(convert_start),
      .i_comp_high(comp_high), .i_over_range, .i_under_range, .o_sw(sw), .o_dac_bits(dac_bits),
      .o_hold(hold), .o_power_up(power_up), .o_busy(busy), .o_done(done), .o_result(result));
   scs_host_model u_scs_host_model (.i_clk_sys, .i_dac_bits(dac_bits), .i_done(done),
      .o_convert_start(convert_start), .o_comp_high(comp_high));
   // Verdict and end of run
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Boundary codes back to back, each result from its own sample
   task automatic t_codes();
      logic [13:0] tbl [7] = '{14'h0000, 14'h2000, 14'h3fff, 14'h1fff, 14'h0001, 14'h2001,
                              14'h1555};
      foreach (tbl[k]) begin
         u_scs_host_model.convert(tbl[k], n);
         `CHK(result, {tbl[k], 2'b00})
         `CHK(n < 197, 1'b1)
      end
   endtask
   // Range flags force the end codes
   task automatic t_range();
      i_over_range = 1'b1;
      u_scs_host_model.convert(14'h0123, n);
      `CHK(result, {CODE_MAX, 2'b10})
      i_over_range = 1'b0;
      i_under_range = 1'b1;
      u_scs_host_model.convert(14'h2abc, n);
      `CHK(result, {CODE_MIN, 2'b01})
      i_under_range = 1'b0;
   endtask
   // Idle: result held, powered down, switches acquiring
   task automatic t_idle();
      u_scs_host_model.convert(14'h0abc, n);
      repeat (50) @(negedge i_clk_sys);
      `CHK(result.code, 14'h0abc)
      `CHK({power_up, busy, hold, sw}, 7'b0001110)
      `CHK({done, dac_bits}, 15'h0000)
   endtask
   // Main sequence
   initial begin
      repeat (3) @(negedge i_clk_sys);
      i_resetn = 1'b1;
      @(negedge i_clk_sys);
      `CHK({result, sw}, 20'h0000e)
      t_codes();
      t_range();
      t_idle();
      stop_test();
   end
   // Watchdog
   initial begin
      #50us;
      n_errors++;
      stop_test();
   end
endmodule
`default_nettype wire
